// File: src/sbcr_pkg.sv
// package: register map, frame layout and preset values of the register bank
package sbcr_pkg;

	// wishbone byte offsets; the scratch word 1 keeps its frame index
	localparam logic [5:0] IDX_GP1     = 6'h03;
	localparam logic [7:0] OFS_GP1     = {IDX_GP1, 2'b00};
	localparam logic [7:0] OFS_FRAME   = 8'h10;
	localparam logic [7:0] OFS_STATUS  = 8'h14;
	localparam logic [7:0] OFS_DIAG    = 8'h18;
	localparam logic [7:0] OFS_PENDING = 8'h1c;

	// serial frame layout
	localparam int unsigned FR_ADDR_HI = 15;
	localparam int unsigned FR_ADDR_LO = 14;
	localparam int unsigned FR_RRS     = 13;
	localparam int unsigned FR_RO      = 12;
	localparam int unsigned DATA_W     = 12;
	localparam int unsigned FRAME_W    = 16;

	// frame register select codes
	localparam logic [1:0] FA_CFG = 2'h0;
	localparam logic [1:0] FA_IE  = 2'h1;
	localparam logic [1:0] FA_GP0 = 2'h2;
	localparam logic [1:0] FA_GP1 = 2'h3;

	// scratch word 0: position of the ident-overwritten flag
	localparam int unsigned GP0_FLAG_BIT = 11;

	// system configuration field positions
	localparam int unsigned CFG_ILC    = 0;
	localparam int unsigned CFG_INHIBIT_OUTPUT_ENABLE   = 1;
	localparam int unsigned CFG_WSC    = 2;
	localparam int unsigned CFG_WEN    = 3;
	localparam int unsigned CFG_MAIN_SUPPLY_CURRENT_WATCH  = 4;
	localparam int unsigned CFG_V3C_LO = 5;
	localparam int unsigned CFG_V3C_HI = 6;
	localparam int unsigned CFG_RLC    = 7;
	localparam int unsigned CFG_GROUND_OFFSET_THRESHOLD_SEL  = 8;
	localparam int unsigned CFG_ERROR_PIN_EMULATION  = 9;
	// power-on value: only wake enable set
	localparam logic [11:0] CFG_POR    = 12'h008;

	// status word field positions
	localparam int unsigned ST_RC_LO  = 0;
	localparam int unsigned ST_RC_HI  = 3;
	localparam int unsigned ST_BWAKE  = 4;
	localparam int unsigned ST_PWAKE  = 5;
	localparam int unsigned ST_ENS    = 6;

	// reset cause codes
	localparam logic [3:0] RC_CODE_0 = 4'h0;
	localparam logic [3:0] RC_CODE_2 = 4'h2;
	localparam logic [3:0] RC_CODE_C = 4'hc;
	localparam logic [3:0] RC_CODE_E = 4'he;

	// diagnosis word: mode[1:0] v1 2 v2 3 v3 4 fault[8:5] gnd 9
	localparam int unsigned DG_W        = 10;
	localparam int unsigned DG_FAULT_LO = 5;
	localparam int unsigned DG_FAULT_HI = 8;
	localparam logic [9:0]  DIAG_POR    = 10'h018;

	// pending interrupt width
	localparam int unsigned IRQ_W = 8;

endpackage

// File: src/sbcr_scratch.sv
// module: one 12-bit scratch word with its feedback copy
module sbcr_scratch
	import sbcr_pkg::*;
#(
	parameter bit          HAS_IDENT  = 1'b0,   // word 0 carries an ident code
	parameter logic [10:0] IDENT_CODE = 11'h000 // arbitrary neutral value
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_store,
	input  wire logic [11:0] i_data,
	output logic      [11:0] o_word
);

	// power-on content: ident code with flag clear, or all zero
	localparam logic [11:0] POR_WORD = HAS_IDENT ? {1'b0, IDENT_CODE}
		: 12'h000;

	// value stored on a write; ident word forces its flag high
	logic [11:0] store_d;

	// the flag ignores what the host wrote into its position
	always_comb begin
		store_d = i_data;
		if (HAS_IDENT) begin
			store_d[GP0_FLAG_BIT] = 1'b1;
		end
	end

	// word register; the feedback copy is the register itself
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_word <= POR_WORD;
		end else if (i_store) begin
			o_word <= store_d;
		end
	end

endmodule

// File: src/sbcr_bank.sv
// module: register bank with frame decode, mode presets and wishbone slave
module sbcr_bank
	import sbcr_pkg::*;
#(
	parameter logic [10:0] IDENT_CODE = 11'h155 // arbitrary neutral value
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// classic wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// mode entry pulses from the mode controller
	input  wire logic        i_startup_entry,
	input  wire logic        i_restart_entry,
	input  wire logic        i_failsafe_entry,
	// status that the rest of the chip feeds in
	input  wire logic [3:0]  i_reset_cause,
	input  wire logic        i_wake_by_bus,
	input  wire logic        i_wake_by_pin,
	input  wire logic [9:0]  i_diag_live,
	input  wire logic [7:0]  i_irq_event,
	input  wire logic [11:0] i_phy_ctrl_fb,
	// configuration and enable pin towards the chip
	output logic      [11:0] o_sys_cfg,
	output logic             o_enable_pin
);

	// true when the bus address matches a register offset
	function automatic logic hit(input logic [7:0] adr,
		input logic [7:0] ofs);
		hit = (adr == ofs);
	endfunction

	// restart may only report one of four cause codes
	function automatic logic restart_code_ok(input logic [3:0] c);
		restart_code_ok = (c == RC_CODE_0) || (c == RC_CODE_2)
			|| (c == RC_CODE_C) || (c == RC_CODE_E);
	endfunction

	// bus handshake helpers
	logic        wb_req;       // new request, not yet answered
	logic        wb_wr;        // write request this cycle
	logic        low_half;     // both low byte lanes enabled
	logic [31:0] rd_mux;       // read data selected by address

	// frame fields taken from the written bus word
	logic [15:0] frame;        // raw frame
	logic [1:0]  frame_sel;    // register_select_bits
	logic        frame_rrs;    // readback_source_select
	logic        frame_ro;     // read_without_store
	logic [11:0] frame_data;   // payload bits
	logic        frame_wr;     // frame write accepted
	logic        frame_store;  // frame also stores its payload

	// per-register store strobes
	logic        cfg_wr;       // configuration store
	logic        ie_wr;        // interrupt enable store
	logic        gp0_wr;       // scratch word 0 store
	logic        gp1_wr;       // scratch word 1 store
	logic [11:0] gp1_data;     // payload for scratch word 1
	logic        pend_clr_wr;  // write-one-to-clear of pending
	logic [11:0] frame_ans;    // answer selected by the frame

	// mode entry helpers
	logic        any_entry;    // start-up or restart entry
	logic        bus_ok;       // live bus fault field is clean

	// state
	logic        ack_q;        // wishbone acknowledge
	logic [31:0] dat_q;        // wishbone read data
	logic [15:0] answer_q;     // last frame answer
	logic [11:0] cfg_q;        // system configuration
	logic [7:0]  ie_q;         // interrupt enable
	logic [7:0]  pend_q;       // pending interrupts
	logic [3:0]  cause_q;      // reset_cause_code
	logic        bwake_q;      // bus_wake_flag
	logic        pwake_q;      // pin_edge_wake_flag
	logic        ens_q;        // enable_pin_state_flag
	logic [9:0]  diag_q;       // diagnosis word
	logic        live_q;       // diagnosis follows live inputs
	logic [11:0] gp0_word;     // user_scratch_word_0 feedback
	logic [11:0] gp1_word;     // user_scratch_word_1 feedback
	logic [11:0] status_word;  // status as read by software

	// request decode; ack_q masks the second cycle of a request so
	// that each write has its side effects exactly once
	assign wb_req   = i_wb_cyc && i_wb_stb && !ack_q;
	assign wb_wr    = wb_req && i_wb_we;
	assign low_half = i_wb_sel[0] && i_wb_sel[1];

	// frame field split
	assign frame      = i_wb_dat[FRAME_W-1:0];
	assign frame_sel  = frame[FR_ADDR_HI:FR_ADDR_LO];
	assign frame_rrs  = frame[FR_RRS];
	assign frame_ro   = frame[FR_RO];
	assign frame_data = frame[DATA_W-1:0];

	// a frame needs both low lanes; a partial frame would be garbage
	assign frame_wr    = wb_wr && low_half && hit(i_wb_adr, OFS_FRAME);
	// read-only frames answer but never store
	assign frame_store = frame_wr && !frame_ro;

	// store strobes per selected register
	assign cfg_wr = frame_store && (frame_sel == FA_CFG);
	assign ie_wr  = frame_store && (frame_sel == FA_IE);
	assign gp0_wr = frame_store && (frame_sel == FA_GP0);
	// scratch word 1: by frame code 11 or by its direct offset
	assign gp1_wr = (frame_store && (frame_sel == FA_GP1))
		|| (wb_wr && low_half && hit(i_wb_adr, OFS_GP1));
	assign gp1_data = hit(i_wb_adr, OFS_GP1) ? i_wb_dat[DATA_W-1:0]
		: frame_data;
	assign pend_clr_wr = wb_wr && i_wb_sel[0]
		&& hit(i_wb_adr, OFS_PENDING);

	// mode entry decode
	assign any_entry = i_startup_entry || i_restart_entry;
	assign bus_ok    = (i_diag_live[DG_FAULT_HI:DG_FAULT_LO] == 4'h0);

	// status word as software sees it
	assign status_word = {5'h00, ens_q, pwake_q, bwake_q, cause_q};

	// frame answer: bit 13 picks the register or its companion; the
	// answer uses the contents from before this frame's store
	always_comb begin
		case (frame_sel)
			FA_CFG: begin
				frame_ans = frame_rrs ? cfg_q : status_word;
			end
			FA_IE: begin
				frame_ans = frame_rrs ? {4'h0, ie_q} : {4'h0, pend_q};
			end
			FA_GP0: begin
				frame_ans = frame_rrs ? gp0_word : cfg_q;
			end
			FA_GP1: begin
				// feedback copy or the phy control feedback
				frame_ans = frame_rrs ? gp1_word : i_phy_ctrl_fb;
			end
			default: begin
				frame_ans = 12'h000;
			end
		endcase
	end

	// bus read mux; unmapped addresses read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit(i_wb_adr, OFS_GP1)) begin
			rd_mux = {20'h00000, gp1_word};
		end else if (hit(i_wb_adr, OFS_FRAME)) begin
			rd_mux = {16'h0000, answer_q};
		end else if (hit(i_wb_adr, OFS_STATUS)) begin
			rd_mux = {20'h00000, status_word};
		end else if (hit(i_wb_adr, OFS_DIAG)) begin
			rd_mux = {22'h0, diag_q};
		end else if (hit(i_wb_adr, OFS_PENDING)) begin
			rd_mux = {24'h000000, pend_q};
		end
	end

	// acknowledge one cycle after the request, dropped the cycle after
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_req;
		end
	end

	// read data captured with the acknowledge, zero for writes
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			dat_q <= 32'h0000_0000;
		end else if (wb_req) begin
			dat_q <= i_wb_we ? 32'h0000_0000 : rd_mux;
		end
	end

	// last frame answer: the top nibble echoes the frame header
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			answer_q <= 16'h0000;
		end else if (frame_wr) begin
			answer_q <= {frame[FRAME_W-1:DATA_W], frame_ans};
		end
	end

	// scratch word 0 carries the ident code until first written
	sbcr_scratch #(
		.HAS_IDENT  (1'b1),
		.IDENT_CODE (IDENT_CODE)
	) u_gp0 (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_store (gp0_wr),
		.i_data  (frame_data),
		.o_word  (gp0_word)
	);

	// scratch word 1: twelve bits with no meaning of their own
	sbcr_scratch #(
		.HAS_IDENT  (1'b0),
		.IDENT_CODE (11'h000)
	) u_gp1 (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_store (gp1_wr),
		.i_data  (gp1_data),
		.o_word  (gp1_word)
	);

	// system configuration; fail-safe outranks restart, restart
	// outranks a host store in the same cycle, start-up changes nothing
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cfg_q <= CFG_POR;
		end else if (i_failsafe_entry) begin
			cfg_q[CFG_RLC]  <= 1'b1;
			cfg_q[CFG_INHIBIT_OUTPUT_ENABLE] <= 1'b1;
			cfg_q[CFG_ILC]  <= 1'b0;
		end else if (i_restart_entry) begin
			cfg_q[CFG_RLC] <= 1'b1;
			// inhibit output floats only if it was driven high
			if (cfg_q[CFG_ILC]) begin
				cfg_q[CFG_INHIBIT_OUTPUT_ENABLE] <= 1'b0;
			end
		end else if (cfg_wr) begin
			// host store; mode entries above leave other fields alone
			cfg_q <= frame_data;
		end
	end

	// interrupt enables survive every mode entry
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			ie_q <= 8'h00;
		end else if (ie_wr) begin
			ie_q <= frame_data[IRQ_W-1:0];
		end
	end

	// pending interrupts: start-up or restart entry clears all, an event beats a host clear
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			pend_q <= 8'h00;
		end else if (any_entry) begin
			pend_q <= 8'h00;
		end else begin
			pend_q <= (pend_q & ~(pend_clr_wr ? i_wb_dat[IRQ_W-1:0]
				: 8'h00)) | (i_irq_event & ie_q);
		end
	end

	// reset cause: illegal codes for a mode keep the previous value,
	// since a wrong cause is worse for software than a stale one
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			cause_q <= RC_CODE_0;
		end else if (i_restart_entry) begin
			if (restart_code_ok(i_reset_cause)) begin
				cause_q <= i_reset_cause;
			end
		end else if (i_startup_entry) begin
			if (i_reset_cause != RC_CODE_C) begin
				cause_q <= i_reset_cause;
			end
		end
	end

	// wake flags: start-up sets the one that woke us, restart keeps
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			bwake_q <= 1'b0;
			pwake_q <= 1'b0;
		end else if (i_startup_entry && !i_restart_entry) begin
			if (i_wake_by_bus) begin
				bwake_q <= 1'b1;
			end
			if (i_wake_by_pin) begin
				pwake_q <= 1'b1;
			end
		end
	end

	// after the first start-up or restart, diagnosis follows live status
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			live_q <= 1'b0;
		end else if (any_entry) begin
			live_q <= 1'b1;
		end
	end

	// diagnosis word: fixed at power-on, then tracks the inputs
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			diag_q <= DIAG_POR;
		end else if (any_entry || live_q) begin
			diag_q <= i_diag_live;
		end
	end

	// enable flag: low unless error emulation shows a clean bus
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			ens_q <= 1'b0;
		end else if (any_entry || live_q) begin
			ens_q <= cfg_q[CFG_ERROR_PIN_EMULATION] && bus_ok;
		end
	end

	// outputs straight from flops
	assign o_wb_ack     = ack_q;
	assign o_wb_dat     = dat_q;
	assign o_sys_cfg    = cfg_q;
	assign o_enable_pin = ens_q;

endmodule

// File: verif/sbcr_bank_assertions.sv
// checker: bus handshake and mode preset relations at the bank ports
module sbcr_bank_chk
	import sbcr_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [31:0] o_wb_dat,
	input  wire logic        o_wb_ack,
	input  wire logic        i_startup_entry,
	input  wire logic        i_restart_entry,
	input  wire logic        i_failsafe_entry,
	input  wire logic [11:0] o_sys_cfg,
	input  wire logic        o_enable_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// a request is taken only while no answer is standing
	sequence s_take;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	// answer is a single cycle pulse
	sequence s_answer;
		o_wb_ack ##1 !o_wb_ack;
	endsequence
	ack_pulse_a: assert property (s_take |=> s_answer)
		else $error("ack missing or longer than one cycle");
	ack_cause_a: assert property ($rose(o_wb_ack)
		|-> $past(i_wb_cyc && i_wb_stb))
		else $error("ack without a request");
	wr_zero_a: assert property ($rose(o_wb_ack) && $past(i_wb_we)
		|-> o_wb_dat == 32'h0)
		else $error("write answer carries data");
	cfg_por_a: assert property (
		$rose(i_rst_b) |-> o_sys_cfg == CFG_POR)
		else $error("configuration power-on value wrong");
	ens_por_a: assert property (
		$rose(i_rst_b) |-> !o_enable_pin)
		else $error("enable flag set at power-on");
	rlc_long_a: assert property (
		i_restart_entry || i_failsafe_entry |=> o_sys_cfg[CFG_RLC])
		else $error("reset length not long after restart");
	inhibit_output_enable_fs_a: assert property (
		i_failsafe_entry |=> o_sys_cfg[CFG_INHIBIT_OUTPUT_ENABLE])
		else $error("inhibit output not active in fail-safe");
	inhibit_output_enable_float_a: assert property (
		i_restart_entry && !i_failsafe_entry && o_sys_cfg[CFG_ILC]
		|=> !o_sys_cfg[CFG_INHIBIT_OUTPUT_ENABLE])
		else $error("inhibit output not floated at restart");
	cfg_kept_a: assert property (
		i_startup_entry && !i_restart_entry && !i_failsafe_entry
		&& !(i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack)
		|=> $stable(o_sys_cfg))
		else $error("configuration changed at start-up");
	ens_off_a: assert property (
		!$past(o_sys_cfg[CFG_ERROR_PIN_EMULATION]) && !o_sys_cfg[CFG_ERROR_PIN_EMULATION]
		|-> !o_enable_pin)
		else $error("enable flag set without emulation");
endmodule

bind sbcr_bank sbcr_bank_chk i_chk (
	.i_clk            (i_clk),
	.i_rst_b          (i_rst_b),
	.i_wb_cyc         (i_wb_cyc),
	.i_wb_stb         (i_wb_stb),
	.i_wb_we          (i_wb_we),
	.o_wb_dat         (o_wb_dat),
	.o_wb_ack         (o_wb_ack),
	.i_startup_entry  (i_startup_entry),
	.i_restart_entry  (i_restart_entry),
	.i_failsafe_entry (i_failsafe_entry),
	.o_sys_cfg        (o_sys_cfg),
	.o_enable_pin     (o_enable_pin)
);

// File: verif/sbcr_host.sv
// host model: wishbone master that carries register and frame accesses
module sbcr_host (
	input  wire logic        i_clk,
	input  wire logic        i_ack,
	input  wire logic [31:0] i_dat,
	output logic             o_cyc,
	output logic             o_stb,
	output logic             o_we,
	output logic      [7:0]  o_adr,
	output logic      [3:0]  o_sel,
	output logic      [31:0] o_dat,
	output logic             o_hung
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero
	initial begin
		{o_cyc, o_stb, o_we, o_hung} = 4'h0;
		o_adr = 8'h00;
		o_sel = 4'h0;
		o_dat = 32'h0;
	end
	// one classic cycle; held until ack is sampled, bounded wait
	task automatic access(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge i_clk);
		o_cyc <= 1'b1;
		o_stb <= 1'b1;
		o_we  <= w;
		o_adr <= a;
		o_sel <= 4'hf;
		o_dat <= d;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			o_hung = 1'b1;
		end
		r = i_dat;
		o_cyc <= 1'b0;
		o_stb <= 1'b0;
		// released we, address and data show inverted values; sel stays all ones
		o_we  <= ~w;
		o_adr <= ~a;
		o_dat <= ~d;
	endtask
endmodule

// File: verif/sbcr_bank_tb.sv
// testbench: register bank presets, frame decode and scratch words
module sbcr_bank_tb
	import sbcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [10:0] ID = 11'h2a3; // arbitrary neutral value
	logic i_clk, i_rst_b, cyc, stb, we, ack, hung, st, rs, fs, bw, pw, enable_pin_state_flag;
	logic [7:0]  adr, irq;
	logic [3:0]  sel, cause;
	logic [31:0] wdat, rdat;
	logic [9:0]  diag;
	logic [11:0] phy, cfg;
	int fails, checks_done;
	sbcr_bank #(.IDENT_CODE(ID)) i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_startup_entry(st), .i_restart_entry(rs), .i_failsafe_entry(fs),
		.i_reset_cause(cause), .i_wake_by_bus(bw), .i_wake_by_pin(pw),
		.i_diag_live(diag), .i_irq_event(irq), .i_phy_ctrl_fb(phy),
		.o_sys_cfg(cfg), .o_enable_pin(enable_pin_state_flag));
	sbcr_host i_host (.i_clk(i_clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc),
		.o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat),
		.o_hung(hung));
	// 100 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		i_host.access(1'b0, a, 32'h0, r);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		i_host.access(1'b1, a, d, r);
	endtask
	// read back a register through the bus and compare
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		check(v, e);
	endtask
	// send a frame, then compare the answer the bank latched for it
	task automatic frame(input logic [1:0] s, input logic r, input logic o,
		input logic [11:0] d, input logic [11:0] e);
		wr(OFS_FRAME, {16'h0, s, r, o, d});
		rdchk(OFS_FRAME, {16'h0, s, r, o, e});
	endtask
	// one-cycle mode entry pulse: {failsafe, restart, startup}
	task automatic mode(input logic [2:0] m);
		@(posedge i_clk);
		{fs, rs, st} <= m;
		@(posedge i_clk);
		{fs, rs, st} <= 3'h0;
	endtask
	task automatic irq_pulse(input logic [7:0] v);
		@(posedge i_clk);
		irq <= v;
		@(posedge i_clk);
		irq <= 8'h00;
	endtask
	task automatic t_por();
		check({20'h0, cfg}, 32'h008);
		check({31'h0, enable_pin_state_flag}, 32'h0);
		rdchk(OFS_STATUS, 32'h0);
		rdchk(OFS_DIAG, 32'h018);
		rdchk(OFS_PENDING, 32'h0);
		frame(FA_IE, 1'b1, 1'b1, 12'h000, 12'h000);
		frame(FA_GP0, 1'b1, 1'b1, 12'h000, {1'b0, ID});
		rdchk(OFS_GP1, 32'h0);
		// unmapped place: acked, write dropped, reads zero
		wr(8'h40, 32'h0000_0fff);
		rdchk(8'h40, 32'h0);
	endtask
	task automatic t_gp1();
		frame(FA_GP1, 1'b1, 1'b0, 12'ha5c, 12'h000);
		frame(FA_GP1, 1'b1, 1'b1, 12'h123, 12'ha5c);
		frame(FA_GP1, 1'b0, 1'b1, 12'h000, 12'h6c9);
		frame(FA_GP1, 1'b1, 1'b0, 12'h5a3, 12'ha5c);
		rdchk(OFS_GP1, 32'h5a3);
		// direct store keeps only the twelve low bits
		wr(OFS_GP1, 32'hffff_f0f0);
		rdchk(OFS_GP1, 32'h0f0);
		frame(FA_GP1, 1'b1, 1'b1, 12'h000, 12'h0f0);
	endtask
	task automatic t_gp0();
		frame(FA_GP0, 1'b1, 1'b0, 12'h0aa, {1'b0, ID});
		frame(FA_GP0, 1'b1, 1'b1, 12'h000, 12'h8aa);
	endtask
	task automatic t_modes();
		// inhibit level high and output enabled, error emulation on
		frame(FA_CFG, 1'b1, 1'b0, 12'h203, 12'h008);
		check({20'h0, cfg}, 32'h203);
		frame(FA_IE, 1'b1, 1'b0, 12'h0ff, 12'h000);
		irq_pulse(8'h81);
		rdchk(OFS_PENDING, 32'h81);
		// host clears bit 0 only; bit 7 stays for the entry to clear
		wr(OFS_PENDING, 32'h0000_0001);
		rdchk(OFS_PENDING, 32'h80);
		diag <= 10'h01c;
		bw <= 1'b1;
		cause <= 4'h5;
		mode(3'b001);
		rdchk(OFS_STATUS, 32'h55);
		rdchk(OFS_DIAG, 32'h01c);
		rdchk(OFS_PENDING, 32'h0);
		frame(FA_IE, 1'b1, 1'b1, 12'h000, 12'h0ff);
		check({20'h0, cfg}, 32'h203);
		// start-up may not show cause 1100; the other wake flag is kept
		bw <= 1'b0;
		pw <= 1'b1;
		cause <= 4'hc;
		mode(3'b001);
		rdchk(OFS_STATUS, 32'h75);
		irq_pulse(8'h01);
		pw <= 1'b0;
		diag <= 10'h03c;
		cause <= 4'he;
		mode(3'b010);
		rdchk(OFS_STATUS, 32'h3e);
		rdchk(OFS_PENDING, 32'h0);
		frame(FA_IE, 1'b1, 1'b1, 12'h000, 12'h0ff);
		check({20'h0, cfg}, 32'h281);
		cause <= 4'h3;
		mode(3'b010);
		rdchk(OFS_STATUS, 32'h3e);
		mode(3'b100);
		// the entry lands at the edge on which mode returns
		@(posedge i_clk);
		check({20'h0, cfg}, 32'h282);
		// restart with the inhibit level low keeps the output active
		mode(3'b010);
		@(posedge i_clk);
		check({20'h0, cfg}, 32'h282);
		// clean bus: the enable flag follows error emulation alone
		diag <= 10'h01c;
		frame(FA_CFG, 1'b1, 1'b0, 12'h082, 12'h282);
		mode(3'b001);
		rdchk(OFS_STATUS, 32'h33);
		frame(FA_CFG, 1'b1, 1'b0, 12'h282, 12'h082);
		rdchk(OFS_STATUS, 32'h73);
	endtask
	task automatic stop_test();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge i_clk);
		fails++;
		stop_test();
	end
	initial begin
		{i_rst_b, st, rs, fs, bw, pw} = 6'h0;
		cause = 4'h0;
		diag = 10'h000;
		irq = 8'h00;
		phy = 12'h6c9;
		fails = 0;
		checks_done = 0;
		repeat (3) @(posedge i_clk);
		i_rst_b <= 1'b1;
		t_por();
		t_gp1();
		t_gp0();
		t_modes();
		// a second power-on must restore every preset
		@(posedge i_clk);
		i_rst_b <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_rst_b <= 1'b1;
		t_por();
		check({31'h0, hung}, 32'h0);
		stop_test();
	end
endmodule
